// ==== rtl/cfg_hdr_pkg.sv ====
// Constants for the main function configuration header slice
package cfg_hdr_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CommandOffset = 8'h04;
  localparam logic [7:0] ClassRevOffset = 8'h08;
  localparam logic [7:0] HeaderTenureOffset = 8'h0c;
  // ==========================================================================
  // Command field bit positions
  localparam int IoDecodeBit = 0;
  localparam int MemDecodeBit = 1;
  localparam int InitiatorBit = 2;
  localparam int MwiBit = 4;
  localparam int SysErrBit = 8;
  localparam logic [15:0] CommandWritableMask = 16'h01f7;
  localparam logic [15:0] CommandReset = 16'h0000;
  // ==========================================================================
  // Fixed identity values
  localparam logic [23:0] ClassCodeValue = 24'h048000;
  localparam logic [7:0] HeaderKindValue = 8'h80;
  // Arbitrary neutral silicon step, not a real part value
  localparam logic [7:0] SiliconStepDefault = 8'h5a;
  // ==========================================================================
  // Latency timer field and scaling
  localparam int TenureLsb = 11;
  localparam int TenureMsb = 15;
  localparam logic [4:0] TenureReset = 5'h00;
  localparam int TenureClocksPerUnit = 8;
  localparam logic [7:0] TenureZero = 8'h00;
endpackage : cfg_hdr_pkg

// ==== rtl/main_accel_function_cfg.sv ====
// Configuration command, class, revision and latency registers of the main function
// Contract
// - The system error driver is enabled only while command bit 8 is one.
// - Memory Write and Invalidate is used only while command bit 4 is one, else plain write.
// - Initiator transactions start only while command bit 2 is one.
// - Memory accesses are claimed only while command bit 1 is one.
// - Command bit 0 is read/write but never makes the function claim I/O accesses.
// - Offset 0x08 bits 31:8 read the fixed class code 0x048000 and ignore writes.
// - Offset 0x08 bits 7:0 read a fixed read-only silicon step identifier.
// - Offset 0x0c reads header kind 0x80 in 23:16 and zero in 31:24 and 10:0.
// - Latency field 15:11 is writable, resets to zero, and means eight clocks per unit.
// - All command enables read zero after reset.
`timescale 1ns/1ps
`default_nettype none
module main_accel_function_cfg
  import cfg_hdr_pkg::*;
#(
  parameter logic [7:0] SILICON_STEP = SiliconStepDefault
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Configuration access (Type 0, already decoded to this function)
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgOffset,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWriteData,
  output logic [31:0]      cfgReadData,
  output logic             cfgReadValid,
  // Target side requests from the bus engine
  input  wire logic        memCycleHit,
  input  wire logic        ioCycleHit,
  output logic             claimMemory,
  output logic             claimIo,
  // Initiator side
  input  wire logic        initiatorRequest,
  input  wire logic        wantInvalidate,
  input  wire logic        busOwned,
  input  wire logic        grantPresent,
  input  wire logic        lineBoundary,
  output logic             initiatorStart,
  output logic             useInvalidate,
  output logic             burstStop,
  // System error
  input  wire logic        sysErrorEvent,
  output logic             sysErrorOut,
  output logic             sysErrorOutEn
);
  // ==========================================================================
  // State
  logic [15:0] command_q;
  logic [15:0] command_d;
  logic [4:0]  tenure_q;
  logic [4:0]  tenure_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic        claimMem_q;
  logic        claimMem_d;
  logic        start_q;
  logic        start_d;
  logic        mwi_q;
  logic        mwi_d;
  logic        stop_q;
  logic        stop_d;
  logic        serrEn_q;
  logic        serrEn_d;
  logic        serr_q;
  logic        serr_d;
  logic        tenureExpired;

  // Byte-lane merge, used for the command register only
  function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) res[7:0] = wd[7:0];
    if (be[1]) res[15:8] = wd[15:8];
    return res;
  endfunction : mergeLow

  // ==========================================================================
  // Register writes; unwritable bits are masked so they stay zero
  always_comb begin
    command_d = command_q;
    tenure_d  = tenure_q;
    if (cfgWrite && cfgOffset == CommandOffset) begin
      command_d = mergeLow(command_q, cfgWriteData[15:0], cfgByteEn[1:0])
                  & CommandWritableMask;
    end
    if (cfgWrite && cfgOffset == HeaderTenureOffset && cfgByteEn[1]) begin
      tenure_d = cfgWriteData[TenureMsb:TenureLsb];
    end
  end

  // ==========================================================================
  // Read mux; class and header values are constants so writes cannot stick
  always_comb begin
    rdata_d  = 32'h0000_0000;
    rvalid_d = cfgRead;
    case (cfgOffset)
      CommandOffset: begin
        rdata_d = {16'h0000, command_q};
      end
      ClassRevOffset: begin
        rdata_d = {ClassCodeValue, SILICON_STEP};
      end
      HeaderTenureOffset: begin
        rdata_d = {8'h00, HeaderKindValue, tenure_q, 11'h000};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
    // Data bus rests at zero between reads so stale words never leak out
    if (!cfgRead) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Bus-facing decisions; claim, start, invalidate and error enable each gated by its command enable
  always_comb begin
    claimMem_d = memCycleHit & command_q[MemDecodeBit];
    start_d    = initiatorRequest & command_q[InitiatorBit];
    mwi_d      = wantInvalidate & command_q[MwiBit];
    stop_d     = busOwned & tenureExpired & ~grantPresent & lineBoundary;
    serrEn_d   = command_q[SysErrBit] & sysErrorEvent;
    serr_d     = 1'b0;
  end

  // Register all state; every output except claimIo comes from here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      command_q  <= CommandReset;
      tenure_q   <= TenureReset;
      rdata_q    <= 32'h0000_0000;
      rvalid_q   <= 1'b0;
      claimMem_q <= 1'b0;
      start_q    <= 1'b0;
      mwi_q      <= 1'b0;
      stop_q     <= 1'b0;
      serrEn_q   <= 1'b0;
      serr_q     <= 1'b0;
    end else begin
      command_q  <= command_d;
      tenure_q   <= tenure_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      claimMem_q <= claimMem_d;
      start_q    <= start_d;
      mwi_q      <= mwi_d;
      stop_q     <= stop_d;
      serrEn_q   <= serrEn_d;
      serr_q     <= serr_d;
    end
  end

  // ==========================================================================
  // Tenure counter instance
  tenure_counter u_tenure (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .tenureUnits   (tenure_q),
    .busOwned      (busOwned),
    .tenureExpired (tenureExpired)
  );

  // Outputs; I/O is never claimed since this function has no I/O space
  assign cfgReadData   = rdata_q;
  assign cfgReadValid  = rvalid_q;
  assign claimMemory   = claimMem_q;
  assign claimIo       = 1'b0;
  assign initiatorStart = start_q;
  assign useInvalidate = mwi_q;
  assign burstStop     = stop_q;
  assign sysErrorOut   = serr_q;                    // Open drain: drives low
  assign sysErrorOutEn = serrEn_q;

  // ==========================================================================
  // Assertions
  property p_serr_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      sysErrorOutEn |-> $past(command_q[SysErrBit]) && $past(sysErrorEvent);
  endproperty
  a_serr_gate: assert property (p_serr_gate)
    else $error("serr driven while disabled");

  property p_mwi_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      (wantInvalidate && command_q[MwiBit]) |=> useInvalidate;
  endproperty
  a_mwi_gate: assert property (p_mwi_gate)
    else $error("invalidate not used when enabled");

  property p_master_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      !command_q[InitiatorBit] |=> !initiatorStart;
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("initiator start while disabled");

  property p_mem_claim;
    @(posedge clk_sys) disable iff (!reset_n)
      memCycleHit |=> (claimMemory == $past(command_q[MemDecodeBit]));
  endproperty
  a_mem_claim: assert property (p_mem_claim)
    else $error("memory claim mismatch");

  property p_no_io;
    @(posedge clk_sys) disable iff (!reset_n)
      ioCycleHit |=> !claimIo;
  endproperty
  a_no_io: assert property (p_no_io)
    else $error("io access claimed");

  property p_class_read;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfgRead && cfgOffset == ClassRevOffset) |=>
        cfgReadValid && cfgReadData == {ClassCodeValue, SILICON_STEP};
  endproperty
  a_class_read: assert property (p_class_read)
    else $error("class code read wrong");

  property p_header_read;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfgRead && cfgOffset == HeaderTenureOffset) |=>
        cfgReadData[31:16] == {8'h00, HeaderKindValue} && cfgReadData[10:0] == 11'h000;
  endproperty
  a_header_read: assert property (p_header_read)
    else $error("header kind read wrong");

  property p_reserved_cmd;
    @(posedge clk_sys) disable iff (!reset_n)
      command_q[15:9] == 7'h00 && !command_q[3];
  endproperty
  a_reserved_cmd: assert property (p_reserved_cmd)
    else $error("reserved command bit set");

  property p_tenure_write;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfgWrite && cfgOffset == HeaderTenureOffset && cfgByteEn[1]) |=>
        tenure_q == $past(cfgWriteData[TenureMsb:TenureLsb]);
  endproperty
  a_tenure_write: assert property (p_tenure_write)
    else $error("latency value not stored");

  property p_stop_cause;
    @(posedge clk_sys) disable iff (!reset_n)
      burstStop |-> $past(tenureExpired) && !$past(grantPresent) && $past(lineBoundary);
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("burst stopped without cause");

  // First edge after release must still show the reset image
  property p_cmd_reset;
    @(posedge clk_sys)
      $rose(reset_n) |-> command_q == CommandReset && tenure_q == TenureReset;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset)
    else $error("command or latency not zero after reset");

  property p_mwi_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (wantInvalidate && !command_q[MwiBit]) |=> !useInvalidate;
  endproperty
  a_mwi_off: assert property (p_mwi_off)
    else $error("invalidate used while disabled");

  property p_claim_cause;
    @(posedge clk_sys) disable iff (!reset_n)
      claimMemory |-> $past(memCycleHit) && $past(command_q[MemDecodeBit]);
  endproperty
  a_claim_cause: assert property (p_claim_cause)
    else $error("memory claimed without hit and enable");

  property p_start_cause;
    @(posedge clk_sys) disable iff (!reset_n)
      initiatorStart |-> $past(initiatorRequest) && $past(command_q[InitiatorBit]);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("initiator start without enable and request");

  property p_serr_follow;
    @(posedge clk_sys) disable iff (!reset_n)
      (sysErrorEvent && command_q[SysErrBit]) |=> sysErrorOutEn && !sysErrorOut;
  endproperty
  a_serr_follow: assert property (p_serr_follow)
    else $error("error line not driven low while enabled");

  // I/O decode bit is plain storage with no effect on claiming
  property p_io_bit;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfgWrite && cfgOffset == CommandOffset && cfgByteEn[0]) |=>
        command_q[IoDecodeBit] == $past(cfgWriteData[IoDecodeBit]);
  endproperty
  a_io_bit: assert property (p_io_bit)
    else $error("io decode bit not stored");

  property p_tenure_read;
    @(posedge clk_sys) disable iff (!reset_n)
      (cfgRead && cfgOffset == HeaderTenureOffset) |=>
        cfgReadData[TenureMsb:TenureLsb] == $past(tenure_q);
  endproperty
  a_tenure_read: assert property (p_tenure_read)
    else $error("latency value read wrong");

  property p_stop_due;
    @(posedge clk_sys) disable iff (!reset_n)
      (busOwned && tenureExpired && !grantPresent && lineBoundary) |=> burstStop;
  endproperty
  a_stop_due: assert property (p_stop_due)
    else $error("burst not stopped after tenure expiry");
endmodule : main_accel_function_cfg
`default_nettype wire

// ==== rtl/tenure_counter.sv ====
// Initiator tenure counter driven by the latency timer field
`timescale 1ns/1ps
`default_nettype none
module tenure_counter
  import cfg_hdr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Control
  input  wire logic [4:0] tenureUnits,
  input  wire logic       busOwned,
  // Status
  output logic            tenureExpired
);
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       expired_q;
  logic       expired_d;

  // ==========================================================================
  // Load units times eight at tenure start, count down while owned
  always_comb begin
    count_d   = count_q;
    expired_d = expired_q;
    if (!busOwned) begin
      count_d   = {tenureUnits, 3'b000};
      expired_d = 1'b0;
    end else if (count_q == TenureZero) begin
      expired_d = 1'b1;
    end else begin
      count_d = count_q - 8'h01;
    end
  end

  // Register the counter state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q   <= TenureZero;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

  assign tenureExpired = expired_q;
endmodule : tenure_counter
`default_nettype wire

// ==== tb/cfg_host_model.sv ====
// Configuration host model issuing single Type 0 accesses to the function
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Configuration cycle
  output logic             cfgRead,
  output logic             cfgWrite,
  output logic [7:0]       cfgOffset,
  output logic [3:0]       cfgByteEn,
  output logic [31:0]      cfgWriteData,
  input  wire logic [31:0] cfgReadData,
  input  wire logic        cfgReadValid
);
  // ==========================================================================
  // Idle state
  initial begin
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    cfgOffset = 8'h00;
    cfgByteEn = 4'h0;
    cfgWriteData = 32'h0000_0000;
  end
  // One strobe per access; qualifiers scramble afterwards so stale values never help
  task access(input logic wr, input logic [7:0] off, input logic [3:0] be,
              input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    // No access while the function is held in reset
    while (!reset_n) @(posedge clk_sys);
    @(posedge clk_sys);
    cfgRead <= !wr;
    cfgWrite <= wr;
    cfgOffset <= off;
    cfgByteEn <= be;
    cfgWriteData <= wd;
    @(posedge clk_sys);
    cfgRead <= 1'b0;
    cfgWrite <= 1'b0;
    cfgOffset <= ~off;
    cfgByteEn <= ~be;
    cfgWriteData <= ~wd;
    #1;
    rd = cfgReadData;
    ok = (cfgReadValid === !wr);
  endtask : access
endmodule : cfg_host_model
`default_nettype wire

// ==== tb/main_accel_function_cfg_bench.sv ====
// Self-checking bench for the main function configuration registers
`timescale 1ns/1ps
`default_nettype none
module main_accel_function_cfg_bench
  import cfg_hdr_pkg::*;
;
  logic clk_sys, reset_n, cfgRead, cfgWrite, cfgReadValid;
  logic [7:0] cfgOffset;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWriteData, cfgReadData, rd;
  logic memCycleHit, ioCycleHit, claimMemory, claimIo, initiatorRequest, wantInvalidate;
  logic busOwned, grantPresent, lineBoundary, initiatorStart, useInvalidate, burstStop;
  logic sysErrorEvent, sysErrorOut, sysErrorOutEn, ok;
  logic [5:0] seenGate, expGate;
  int n_fail, num_checks, cycles, cnt;
  logic [15:0] cmdTab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0100};
  main_accel_function_cfg dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .cfgRead(cfgRead),
    .cfgWrite(cfgWrite), .cfgOffset(cfgOffset), .cfgByteEn(cfgByteEn),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
    .memCycleHit(memCycleHit), .ioCycleHit(ioCycleHit), .claimMemory(claimMemory),
    .claimIo(claimIo), .initiatorRequest(initiatorRequest), .wantInvalidate(wantInvalidate),
    .busOwned(busOwned), .grantPresent(grantPresent), .lineBoundary(lineBoundary),
    .initiatorStart(initiatorStart), .useInvalidate(useInvalidate), .burstStop(burstStop),
    .sysErrorEvent(sysErrorEvent), .sysErrorOut(sysErrorOut), .sysErrorOutEn(sysErrorOutEn));
  cfg_host_model host_u (.clk_sys(clk_sys), .reset_n(reset_n), .cfgRead(cfgRead),
    .cfgWrite(cfgWrite), .cfgOffset(cfgOffset), .cfgByteEn(cfgByteEn),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid));
  // ==========================================================================
  // Clock, reset and hang guard; ceiling sized well above the whole sequence
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task cfg(input logic wr, input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
    host_u.access(wr, off, be, wd, rd, ok);
    check(ok, 1'b1);
  endtask : cfg
  // ==========================================================================
  // Scenarios
  task t_reset_values();
    cfg(1'b0, CommandOffset, 4'hf, 32'h0);
    check(rd, 32'h0000_0000);
    cfg(1'b0, ClassRevOffset, 4'hf, 32'h0);
    check(rd, {24'h048000, 8'h5a});
    cfg(1'b0, HeaderTenureOffset, 4'hf, 32'h0);
    check(rd, 32'h0080_0000);
  endtask : t_reset_values
  task t_write_masks();
    cfg(1'b1, CommandOffset, 4'hf, 32'hffff_ffff);
    cfg(1'b0, CommandOffset, 4'hf, 32'h0);
    check(rd, 32'h0000_01f7);
    cfg(1'b1, ClassRevOffset, 4'hf, 32'h0000_0000);
    cfg(1'b0, ClassRevOffset, 4'hf, 32'h0);
    check(rd, {24'h048000, 8'h5a});
    cfg(1'b1, HeaderTenureOffset, 4'hf, 32'hffff_ffff);
    cfg(1'b0, HeaderTenureOffset, 4'hf, 32'h0);
    check(rd, 32'h0080_f800);
    cfg(1'b1, 8'h40, 4'hf, 32'hffff_ffff);
    cfg(1'b0, 8'h40, 4'hf, 32'h0);
    check(rd, 32'h0000_0000);
  endtask : t_write_masks
  // Every enable alone, all requests held high, outputs follow one cycle later
  task t_gating();
    @(posedge clk_sys);
    memCycleHit <= 1'b1;
    ioCycleHit <= 1'b1;
    initiatorRequest <= 1'b1;
    wantInvalidate <= 1'b1;
    sysErrorEvent <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cfg(1'b1, CommandOffset, 4'h3, {16'h0, cmdTab[i]});
      @(posedge clk_sys);
      #1;
      seenGate = {claimMemory, claimIo, initiatorStart, useInvalidate, sysErrorOutEn, sysErrorOut};
      expGate = {cmdTab[i][1], 1'b0, cmdTab[i][2], cmdTab[i][4], cmdTab[i][8], 1'b0};
      check(seenGate, expGate);
    end
    @(posedge clk_sys);
    {memCycleHit, ioCycleHit, initiatorRequest, wantInvalidate, sysErrorEvent} <= 5'h00;
  endtask : t_gating
  // Two units of eight clocks; no stop while grant stays, then stop once grant is gone
  task t_tenure();
    cfg(1'b1, HeaderTenureOffset, 4'h2, 32'h0000_1000);
    @(posedge clk_sys);
    grantPresent <= 1'b1;
    lineBoundary <= 1'b1;
    busOwned <= 1'b1;
    cnt = 0;
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      cnt = cnt + (burstStop === 1'b1);
    end
    check(cnt, 0);
    @(posedge clk_sys);
    busOwned <= 1'b0;
    grantPresent <= 1'b0;
    repeat (3) @(posedge clk_sys);
    busOwned <= 1'b1;
    cnt = 0;
    while (burstStop !== 1'b1 && cnt < 40) begin
      @(posedge clk_sys);
      #1;
      cnt = cnt + 1;
    end
    // Expiry flag and registered stop add two edges to the programmed count
    check(cnt, 2 * TenureClocksPerUnit + 2);
    @(posedge clk_sys);
    {busOwned, lineBoundary} <= 2'h0;
  endtask : t_tenure
  // Reset in mid-run must clear command and latency again
  task t_mid_reset();
    cfg(1'b1, CommandOffset, 4'h3, 32'h0000_0117);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    cfg(1'b0, CommandOffset, 4'hf, 32'h0);
    check(rd, 32'h0000_0000);
    cfg(1'b0, HeaderTenureOffset, 4'hf, 32'h0);
    check(rd, 32'h0080_0000);
  endtask : t_mid_reset
  // ==========================================================================
  // Main sequence
  initial begin
    {memCycleHit, ioCycleHit, initiatorRequest, wantInvalidate} = 4'h0;
    {busOwned, grantPresent, lineBoundary, sysErrorEvent} = 4'h0;
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset_values();
    t_write_masks();
    t_gating();
    t_tenure();
    t_mid_reset();
    conclude();
  end
endmodule : main_accel_function_cfg_bench
`default_nettype wire
